// ===== rss_pkg.sv
// Constants for the rotate, subtract and sleep execution block
`default_nettype none
package rss_pkg;

  // Register byte offsets on the bus
  localparam logic [11:0] RSS_CMD_OFS    = 12'h000;
  localparam logic [11:0] RSS_WREG_OFS   = 12'h004;
  localparam logic [11:0] RSS_STATUS_OFS = 12'h008;
  localparam logic [11:0] RSS_DOG_OFS    = 12'h00C;
  localparam logic [11:0] RSS_WAKE_OFS   = 12'h010;
  // File memory window: 0x200 + 4 * file address
  localparam logic [2:0]  RSS_FILE_WIN   = 3'h1;

  // Command word fields
  localparam int RSS_OP_LSB   = 0;
  localparam int RSS_OP_MSB   = 3;
  localparam int RSS_DEST_BIT = 4;
  localparam int RSS_FA_LSB   = 8;
  localparam int RSS_FA_MSB   = 14;
  localparam int RSS_LIT_LSB  = 16;
  localparam int RSS_LIT_MSB  = 23;

  // Status register bit positions
  localparam int RSS_ST_C     = 0;
  localparam int RSS_ST_NC    = 1;
  localparam int RSS_ST_Z     = 2;
  localparam int RSS_ST_PDN_N = 3;
  localparam int RSS_ST_TMO_N = 4;
  localparam int RSS_ST_SLEEP = 8;
  localparam int RSS_ST_OSC   = 9;

  // Operation codes
  localparam logic [3:0] RSS_OP_NONE   = 4'h0;
  localparam logic [3:0] RSS_OP_ROT    = 4'h1;
  localparam logic [3:0] RSS_OP_LSUB   = 4'h2;
  localparam logic [3:0] RSS_OP_FSUB   = 4'h3;
  localparam logic [3:0] RSS_OP_FSUBB  = 4'h4;
  localparam logic [3:0] RSS_OP_SLEEP  = 4'h5;

  // Values after reset
  localparam logic       RSS_RST_PDN_N = 1'b1;
  localparam logic       RSS_RST_TMO_N = 1'b1;
  localparam logic       RSS_RST_OSC   = 1'b1;
  localparam logic       RSS_RST_READY = 1'b1;

endpackage
`default_nettype wire

// ===== rss_exec.sv
// Rotate, subtract and sleep execution datapath with AHB-Lite registers
// How it works
// (RULE_01) Destination bit 0 writes working register, 1 writes addressed file register.
// (RULE_02) Rotate right: carry into bit 7, bit 0 into carry; only carry changes.
// (RULE_03) Literal minus working register, two's complement, result into working register.
// (RULE_04) Literal subtract updates carry, nibble carry, zero; carry clear when working exceeds literal.
// (RULE_05) Digit carry clear when working low nibble exceeds other low nibble.
// (RULE_06) Sleep clears watchdog counter and its prescaler.
// (RULE_07) Sleep clears power-down flag, sets time-out flag, nothing else.
// (RULE_08) After sleep, execution halts and oscillator stops.
// (RULE_09) File minus working register updates all three flags, destination selectable.
// (RULE_10) File minus working minus inverted carry, flags updated, destination selectable.
// (RULE_11) Zero set when 8-bit result is zero; carry means no borrow.
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`default_nettype none
module rss_exec
  import rss_pkg::*;
#(
  parameter int DOG_BITS = 8,
  parameter int PRE_BITS = 8
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Power state
  output logic             sleep_active,
  output logic             osc_enable
);

  // Widths must fit their watchdog register fields
  generate
    if (DOG_BITS < 1 || DOG_BITS > 8 || PRE_BITS < 1 || PRE_BITS > 8)
    begin : g_bad_param
      $error("rss_exec: DOG_BITS and PRE_BITS must be 1 to 8");
    end
  endgenerate

  typedef struct packed {
    logic                 pend;        // Data phase owed
    logic                 pend_write;
    logic [11:0]          addr;
    logic                 ready;
    logic [31:0]          rdata;
    logic [7:0]           wreg;
    logic                 c;
    logic                 nc;
    logic                 z;
    logic                 pdn_n;
    logic                 tmo_n;
    logic                 sleeping;
    logic                 osc_en;
    logic [DOG_BITS-1:0]  dog;
    logic [PRE_BITS-1:0]  pre;
    logic [23:0]          last_cmd;
    logic [127:0][7:0]    file;
  } rss_state_type;

  localparam rss_state_type STATE_RST = '{
    ready:    RSS_RST_READY,
    pdn_n:    RSS_RST_PDN_N,
    tmo_n:    RSS_RST_TMO_N,
    osc_en:   RSS_RST_OSC,
    default:  '0
  };

  rss_state_type state_reg;
  rss_state_type state_next;

  // Decoded command and ALU results
  logic        wr_apply;
  logic        cmd_hit;
  logic        exec;
  logic [3:0]  cmd_op;
  logic        cmd_dest;
  logic [6:0]  cmd_faddr;
  logic [7:0]  cmd_lit;
  logic [7:0]  fval;
  logic [7:0]  opa;
  logic [7:0]  opb;
  logic        bin;
  logic [8:0]  diff9;
  logic [4:0]  diffn;
  logic [7:0]  alu_res;
  logic        alu_c;
  logic        alu_nc;
  logic        alu_z;
  logic        is_sub;
  logic        is_fop;

  // Command decode from the write data phase
  always_comb
  begin
    wr_apply  = state_reg.pend && state_reg.pend_write;
    cmd_hit   = wr_apply && (state_reg.addr == RSS_CMD_OFS);
    cmd_op    = hwdata[RSS_OP_MSB:RSS_OP_LSB];
    cmd_dest  = hwdata[RSS_DEST_BIT];
    cmd_faddr = hwdata[RSS_FA_MSB:RSS_FA_LSB];
    cmd_lit   = hwdata[RSS_LIT_MSB:RSS_LIT_LSB];
    // (RULE_08) halted while asleep
    exec      = cmd_hit && !state_reg.sleeping;
    fval      = state_reg.file[cmd_faddr];
    // (RULE_09) file subtract decoded
    is_sub    = (cmd_op == RSS_OP_LSUB) || (cmd_op == RSS_OP_FSUB) || (cmd_op == RSS_OP_FSUBB);
    is_fop    = (cmd_op == RSS_OP_ROT) || (cmd_op == RSS_OP_FSUB) || (cmd_op == RSS_OP_FSUBB);
  end

  // Subtractor and rotator
  always_comb
  begin
    // (RULE_03) literal is minuend
    opa = (cmd_op == RSS_OP_LSUB) ? cmd_lit : fval;
    opb = state_reg.wreg;
    // (RULE_10) borrow is inverted carry
    bin = (cmd_op == RSS_OP_FSUBB) ? ~state_reg.c : 1'b0;
    diff9 = {1'b0, opa} - {1'b0, opb} - {8'h00, bin};
    // (RULE_05) low nibble borrow
    diffn = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, bin};
    if (cmd_op == RSS_OP_ROT)
    begin
      // (RULE_02) carry in at bit 7
      alu_res = {state_reg.c, fval[7:1]};
      alu_c   = fval[0];
    end
    else
    begin
      alu_res = diff9[7:0];
      // (RULE_11) carry as no-borrow
      alu_c   = ~diff9[8];
    end
    alu_nc = ~diffn[4];
    // (RULE_11) zero on zero result
    alu_z  = (diff9[7:0] == 8'h00);
  end

  // Next state: bus, execution, watchdog
  always_comb
  begin
    state_next = state_reg;
    // Watchdog prescaler feeds the counter
    state_next.pre = state_reg.pre + PRE_BITS'(1);
    if (&state_reg.pre)
    begin
      state_next.dog = state_reg.dog + DOG_BITS'(1);
      if (&state_reg.dog)
      begin
        state_next.tmo_n = 1'b0;
      end
    end
    // Data phase: one wait state, then answer
    state_next.ready = 1'b1;
    if (state_reg.pend)
    begin
      state_next.pend  = 1'b0;
      state_next.rdata = 32'h0000_0000;
      if (!state_reg.pend_write)
      begin
        case (state_reg.addr)
          RSS_CMD_OFS:    state_next.rdata = {8'h00, state_reg.last_cmd};
          RSS_WREG_OFS:   state_next.rdata = {24'h00_0000, state_reg.wreg};
          RSS_STATUS_OFS:
          begin
            state_next.rdata[RSS_ST_C]     = state_reg.c;
            state_next.rdata[RSS_ST_NC]    = state_reg.nc;
            state_next.rdata[RSS_ST_Z]     = state_reg.z;
            state_next.rdata[RSS_ST_PDN_N] = state_reg.pdn_n;
            state_next.rdata[RSS_ST_TMO_N] = state_reg.tmo_n;
            state_next.rdata[RSS_ST_SLEEP] = state_reg.sleeping;
            state_next.rdata[RSS_ST_OSC]   = state_reg.osc_en;
          end
          RSS_DOG_OFS:
          begin
            state_next.rdata[DOG_BITS-1:0] = state_reg.dog;
            state_next.rdata[8 +: PRE_BITS] = state_reg.pre;
          end
          default:
          begin
            if (state_reg.addr[11:9] == RSS_FILE_WIN)
            begin
              state_next.rdata = {24'h00_0000, state_reg.file[state_reg.addr[8:2]]};
            end
          end
        endcase
      end
      else
      begin
        case (state_reg.addr)
          RSS_WREG_OFS:   state_next.wreg = hwdata[7:0];
          RSS_STATUS_OFS:
          begin
            state_next.c  = hwdata[RSS_ST_C];
            state_next.nc = hwdata[RSS_ST_NC];
            state_next.z  = hwdata[RSS_ST_Z];
          end
          RSS_WAKE_OFS:
          begin
            state_next.sleeping = 1'b0;
            state_next.osc_en   = 1'b1;
          end
          RSS_CMD_OFS:    state_next.last_cmd = hwdata[23:0];
          default:
          begin
            if (state_reg.addr[11:9] == RSS_FILE_WIN)
            begin
              state_next.file[state_reg.addr[8:2]] = hwdata[7:0];
            end
          end
        endcase
      end
    end
    // Instruction execution
    if (exec)
    begin
      if (is_fop || is_sub)
      begin
        // (RULE_01) destination select
        if (is_fop && cmd_dest)
        begin
          state_next.file[cmd_faddr] = alu_res;
        end
        else
        begin
          state_next.wreg = alu_res;
        end
        state_next.c = alu_c;
      end
      if (is_sub)
      begin
        // (RULE_04) subtract flag update
        state_next.nc = alu_nc;
        state_next.z  = alu_z;
      end
      if (cmd_op == RSS_OP_SLEEP)
      begin
        // (RULE_06) watchdog cleared
        state_next.dog      = '0;
        state_next.pre      = '0;
        // (RULE_07) power flags set
        state_next.pdn_n    = 1'b0;
        state_next.tmo_n    = 1'b1;
        // (RULE_08) halt and stop oscillator
        state_next.sleeping = 1'b1;
        state_next.osc_en   = 1'b0;
      end
    end
    // Address phase capture
    if (hsel && hready && htrans[1])
    begin
      state_next.pend       = 1'b1;
      state_next.pend_write = hwrite;
      state_next.addr       = haddr[11:0];
      state_next.ready      = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= STATE_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from state, except hresp tied low
  assign hreadyout    = state_reg.ready;
  assign hrdata       = state_reg.rdata;
  assign hresp        = 1'b0;
  assign sleep_active = state_reg.sleeping;
  assign osc_enable   = state_reg.osc_en;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Destination working register
  property p_dest_w;
    exec && is_fop && !cmd_dest |=> state_reg.wreg == $past(alu_res);
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("result not in working register"); // RULE_01

  // Destination file register
  property p_dest_f;
    exec && is_fop && cmd_dest |=> state_reg.file[$past(cmd_faddr)] == $past(alu_res)
      && $stable(state_reg.wreg);
  endproperty
  a_dest_f: assert property (p_dest_f) else $error("result not in file register"); // RULE_01

  // Rotate through carry
  property p_rot;
    exec && cmd_op == RSS_OP_ROT
      |=> state_reg.c == $past(fval[0]) && $stable(state_reg.z) && $stable(state_reg.nc);
  endproperty
  a_rot: assert property (p_rot) else $error("rotate carry wrong"); // RULE_02

  // Literal subtract result and carry
  property p_lsub;
    exec && cmd_op == RSS_OP_LSUB
      |=> state_reg.wreg == $past(cmd_lit) - $past(state_reg.wreg)
        && state_reg.c == ($past(state_reg.wreg) <= $past(cmd_lit));
  endproperty
  a_lsub: assert property (p_lsub) else $error("literal subtract wrong"); // RULE_03

  // Literal subtract nibble carry
  property p_lsub_nc;
    exec && cmd_op == RSS_OP_LSUB
      |=> state_reg.nc == ($past(state_reg.wreg[3:0]) <= $past(cmd_lit[3:0]));
  endproperty
  a_lsub_nc: assert property (p_lsub_nc) else $error("nibble carry wrong"); // RULE_05

  // File subtract carry
  property p_fsub;
    exec && cmd_op == RSS_OP_FSUB
      |=> state_reg.c == ($past(state_reg.wreg) <= $past(fval));
  endproperty
  a_fsub: assert property (p_fsub) else $error("file subtract carry wrong"); // RULE_09

  // Subtract with borrow result
  property p_fsubb;
    exec && cmd_op == RSS_OP_FSUBB && !cmd_dest
      |=> state_reg.wreg == 8'($past(fval) - $past(state_reg.wreg) - {7'h00, ~$past(state_reg.c)});
  endproperty
  a_fsubb: assert property (p_fsubb) else $error("borrow subtract wrong"); // RULE_10

  // Zero flag
  property p_zero;
    exec && is_sub |=> state_reg.z == ($past(alu_res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // RULE_11

  // Sleep clears watchdog
  property p_sleep_dog;
    exec && cmd_op == RSS_OP_SLEEP |=> state_reg.dog == '0 ##1 state_reg.pre == PRE_BITS'(1);
  endproperty
  a_sleep_dog: assert property (p_sleep_dog) else $error("watchdog not cleared"); // RULE_06

  // Sleep power flags
  property p_sleep_flags;
    exec && cmd_op == RSS_OP_SLEEP
      |=> !state_reg.pdn_n && state_reg.tmo_n && $stable(state_reg.c) && $stable(state_reg.z);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("power flags wrong"); // RULE_07

  // Halted while asleep
  property p_halt;
    cmd_hit && state_reg.sleeping && !$past(exec) |=> $stable(state_reg.c) && !osc_enable;
  endproperty
  a_halt: assert property (p_halt) else $error("executed while asleep"); // RULE_08

endmodule
`default_nettype wire

// ===== rss_host.sv
// Bus master model standing in for the decoder side of the block
`default_nettype none
module rss_host
(
  // Clock
  input  wire logic        ref_clk,
  // Master request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // Slave answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One word transfer; waits on hready with no fixed latency
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    haddr <= ~{20'h0, a}; // Stale address scrambled
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    r = hrdata;
    hwdata <= ~d; // Released data scrambled
  endtask
endmodule
`default_nettype wire

// ===== rotate_subtract_sleep_exec_test.sv
// Self-checking testbench for the rotate, subtract and sleep block
`default_nettype none
module rotate_subtract_sleep_exec_test import rss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, arst_n, hsel, hwrite, hreadyout, hresp;
  logic        sleep_active, osc_enable;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          failures, tests_run;

  // Short watchdog counts so a wrap fits the run
  rss_exec #(.DOG_BITS(4), .PRE_BITS(2)) i_rss_exec (.ref_clk(ref_clk), .arst_n(arst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sleep_active(sleep_active), .osc_enable(osc_enable));
  rss_host i_rss_host (.ref_clk(ref_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  // Clock source
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Counts and verdict
  task automatic results();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Compare one value
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus helpers
  task automatic wr(logic [11:0] a, logic [31:0] d);
    i_rss_host.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdc(logic [11:0] a, logic [31:0] m, logic [31:0] e);
    i_rss_host.xfer(1'b0, a, 32'h0, rd);
    chk(rd & m, e);
  endtask
  function automatic logic [11:0] fa(logic [6:0] f);
    return {RSS_FILE_WIN, f, 2'b00};
  endfunction
  task automatic cmd(logic [3:0] op, logic d, logic [6:0] f, logic [7:0] k);
    wr(RSS_CMD_OFS, {8'h0, k, 1'b0, f, 3'h0, d, op});
  endtask

  // Loads operands, runs one op, checks W, file and flags
  task automatic run(logic [3:0] op, logic d, logic [6:0] f, logic [7:0] w, v, k, logic [2:0] s);
    logic [7:0] a;
    logic       c;
    logic [8:0] r;
    logic [4:0] n;
    logic [2:0] e;
    wr(RSS_WREG_OFS, {24'h0, w});
    wr(fa(f), {24'h0, v});
    wr(RSS_STATUS_OFS, {29'h0, s});
    cmd(op, d, f, k);
    a = (op == RSS_OP_LSUB) ? k : v;
    c = (op == RSS_OP_FSUBB) ? s[0] : 1'b1;
    r = {1'b0, a} + {1'b0, ~w} + {8'h0, c};
    n = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + {4'h0, c};
    e = {r[7:0] == 8'h00, n[4], r[8]};
    if (op == RSS_OP_ROT)
    begin
      r = {v[0], s[0], v[7:1]};
      e = {s[2:1], v[0]};
    end
    rdc(RSS_WREG_OFS, 32'hFF, {24'h0, d ? w : r[7:0]});
    rdc(fa(f), 32'hFF, {24'h0, d ? r[7:0] : v});
    rdc(RSS_STATUS_OFS, 32'h7, {29'h0, e});
  endtask

  // Reset values and an unmapped place
  task automatic t_reset();
    chk({30'h0, sleep_active, osc_enable}, 32'h1);
    rdc(RSS_STATUS_OFS, 32'h318, 32'h218);
    wr(12'h100, 32'hFFFF_FFFF);
    rdc(12'h100, 32'hFFFF_FFFF, 32'h0);
  endtask

  // Rotate right with carry in clear and set, both destinations
  task automatic t_rotate();
    run(RSS_OP_ROT, 1'b0, 7'h05, 8'h11, 8'hE6, 8'h00, 3'h6);
    run(RSS_OP_ROT, 1'b1, 7'h7F, 8'h11, 8'h01, 8'h00, 3'h7);
  endtask

  // Literal minus W at equal, borrow and edge values
  task automatic t_lsub();
    logic [15:0] tbl [4] = '{16'h0505, 16'h0605, 16'h1F20, 16'h00FF};
    foreach (tbl[i])
      run(RSS_OP_LSUB, 1'b0, 7'h00, tbl[i][15:8], 8'h5A, tbl[i][7:0], 3'h0);
  endtask

  // File minus W into each destination
  task automatic t_fsub();
    run(RSS_OP_FSUB, 1'b0, 7'h0A, 8'h31, 8'h30, 8'h00, 3'h0);
    run(RSS_OP_FSUB, 1'b1, 7'h7F, 8'h0F, 8'h10, 8'h00, 3'h7);
  endtask

  // File minus W with borrow in and out
  task automatic t_fsubb();
    run(RSS_OP_FSUBB, 1'b1, 7'h03, 8'h0F, 8'h10, 8'h00, 3'h0);
    run(RSS_OP_FSUBB, 1'b0, 7'h03, 8'h00, 8'h00, 8'h00, 3'h1);
    run(RSS_OP_FSUBB, 1'b0, 7'h03, 8'h01, 8'h00, 8'h00, 3'h0);
  endtask

  // Sleep after a watchdog wrap, refused op, wake
  task automatic t_sleep();
    repeat (70) @(posedge ref_clk);
    rdc(RSS_STATUS_OFS, 32'h10, 32'h0);
    wr(RSS_STATUS_OFS, 32'h5);
    cmd(RSS_OP_SLEEP, 1'b0, 7'h00, 8'h00);
    i_rss_host.xfer(1'b0, RSS_DOG_OFS, 32'h0, rd);
    chk({31'h0, rd[3:0] <= 4'h1}, 32'h1);
    chk({30'h0, sleep_active, osc_enable}, 32'h2);
    rdc(RSS_STATUS_OFS, 32'h31F, 32'h115);
    wr(RSS_WREG_OFS, 32'h3);
    cmd(RSS_OP_LSUB, 1'b0, 7'h00, 8'h03);
    rdc(RSS_WREG_OFS, 32'hFF, 32'h3);
    wr(RSS_WAKE_OFS, 32'h1);
    chk({30'h0, sleep_active, osc_enable}, 32'h1);
  endtask

  // Reset, then the scenarios
  initial
  begin
    arst_n = 1'b0;
    failures = 0;
    tests_run = 0;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset();
    t_rotate();
    t_lsub();
    t_fsub();
    t_fsubb();
    t_sleep();
    results();
  end

  // Hang guard, well past the expected run
  initial
  begin
    #20000;
    failures++;
    results();
  end
endmodule
`default_nettype wire
